/* File: rtl/cfas_pkg.sv */
// Constants shared by the frame address and status block
`default_nettype none
package cfas_pkg;
  // ---------------------------------------------------------------
  // Frame geometry
  // ---------------------------------------------------------------
  localparam int unsigned FRAME_BITS  = 1312;
  localparam int unsigned WORD_BITS   = 32;
  localparam int unsigned FRAME_WORDS = FRAME_BITS / WORD_BITS;
  localparam logic [5:0]  LAST_WORD   = 6'(FRAME_WORDS - 1);
  localparam logic [5:0]  CLKROW_WORD = 6'h14;
  // ---------------------------------------------------------------
  // Frame address fields
  // ---------------------------------------------------------------
  localparam int unsigned HALF_BIT   = 22;
  localparam int unsigned TYPE_HI    = 21;
  localparam int unsigned TYPE_LO    = 19;
  localparam int unsigned ROW_HI     = 18;
  localparam int unsigned ROW_LO     = 14;
  localparam int unsigned COL_HI     = 13;
  localparam int unsigned COL_LO     = 6;
  localparam int unsigned MINOR_HI   = 5;
  localparam int unsigned MINOR_LO   = 0;
  localparam int unsigned ADDR_BITS  = 23;
  localparam logic [2:0]  TYPE_LOGIC = 3'h0;
  localparam logic [2:0]  TYPE_MEMIC = 3'h1;
  localparam logic [2:0]  TYPE_MEMCT = 3'h2;
  localparam logic [2:0]  TYPE_SPEC0 = 3'h3;
  localparam logic [2:0]  TYPE_SPEC1 = 3'h4;
  localparam logic [31:0] FAR_RESET  = 32'h0000_0000;
  // ---------------------------------------------------------------
  // Register selects on the configuration port
  // ---------------------------------------------------------------
  localparam logic [4:0]  SEL_FAR  = 5'h01;
  localparam logic [4:0]  SEL_FRAME_DATA_INPUT = 5'h02;
  localparam logic [4:0]  SEL_STAT = 5'h07;
  // ---------------------------------------------------------------
  // Status bit positions
  // ---------------------------------------------------------------
  localparam int unsigned ST_DECRYPT = 16;
  localparam int unsigned ST_IDENT   = 15;
  localparam int unsigned ST_DONEPIN = 14;
  localparam int unsigned ST_RELEASE = 13;
  localparam int unsigned ST_INITPIN = 12;
  localparam int unsigned ST_INITOK  = 11;
  localparam int unsigned ST_MODE_HI = 10;
  localparam int unsigned ST_MODE_LO = 8;
  localparam int unsigned ST_GHIGH   = 7;
  localparam int unsigned ST_GWE     = 6;
  localparam int unsigned ST_GTS     = 5;
  localparam int unsigned ST_EOS     = 4;
  localparam int unsigned ST_MATCH   = 3;
  localparam int unsigned ST_LOCK    = 2;
  localparam int unsigned ST_SECURE  = 1;
  localparam int unsigned ST_CRC     = 0;
  localparam int unsigned NUM_BANKS  = 8;
  localparam int unsigned NUM_CLKMGR = 4;
endpackage
`default_nettype wire

/* File: rtl/cfas_frame_if.sv */
// Interface between the address holder and the word sequencer
`default_nettype none
interface cfas_frame_if;
  logic       word_ok;
  logic       bottom;
  logic       restart;
  logic [5:0] word_idx;
  logic [5:0] place_idx;
  logic       keep_order;
  logic       frame_done;
  modport ctrl (output word_ok, output bottom, output restart,
                input word_idx, input place_idx, input keep_order, input frame_done);
  modport seq  (input word_ok, input bottom, input restart,
                output word_idx, output place_idx, output keep_order, output frame_done);
endinterface
`default_nettype wire

/* File: rtl/cfas_word_seq.sv */
// Word counter within one frame, with bottom-half mirroring
`default_nettype none
module cfas_word_seq
  import cfas_pkg::*;
(
  input  wire logic   sys_clk_in,
  input  wire logic   nrst_in,
  cfas_frame_if.seq   fr
);
  // ---------------------------------------------------------------
  // Word count
  // ---------------------------------------------------------------
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic       last_w;

  // Frame closes on the last of its fixed word count
  assign last_w  = (cnt_r == LAST_WORD);
  assign cnt_nxt = fr.restart ? 6'h00 :
                   !fr.word_ok ? cnt_r :
                   last_w ? 6'h00 : 6'(cnt_r + 6'h01);

  // Counter register
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r <= 6'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Placement of the current word
  // ---------------------------------------------------------------
  // Bottom frames land reversed, except the clock row word
  assign fr.word_idx   = cnt_r;
  assign fr.keep_order = !fr.bottom || (cnt_r == CLKROW_WORD);
  assign fr.place_idx  = fr.bottom ? 6'(LAST_WORD - cnt_r) : cnt_r;
  assign fr.frame_done = fr.word_ok && last_w && !fr.restart;
endmodule
`default_nettype wire

/* File: rtl/cfas_top.sv */
// Frame address register, frame word steering and global status register
// Operation
// - Frames are 41 words; advance after that
// - Bottom frames mirrored, clock row order kept
// - Address written directly or auto-incremented per frame
// - Bit 22 picks top or bottom half
// - Bits 21:19 give block type
// - Bits 18:14 select row, outward from middle
// - Bits 13:6 select major column, left first
// - Bits 5:0 select memory-cell address line
// - Status readable over parallel or JTAG port
// - Bit 16 flags data write outside decryption
// - Bit 15 flags data write without identifier
// - Bit 13 shows internal completion release
// - Bit 11 shows initialization finished
// - Bits 10:8 show sampled mode pins
// - Bit 6 shows global write enable
// - Bit 5 shows global three-state level
// - Bit 4 shows startup finished
// - Bit 3 ANDs all bank impedance matches
// - Bit 2 ANDs all clock manager locks
// - Bit 1 shows decryptor secured
`default_nettype none
module cfas_top
  import cfas_pkg::*;
(
  input  wire logic                  sys_clk_in,
  input  wire logic                  nrst_in,
  // Configuration port register access
  input  wire logic                  cfg_wr_in,
  input  wire logic                  cfg_rd_in,
  input  wire logic [4:0]            cfg_sel_in,
  input  wire logic [31:0]           cfg_wdata_in,
  output logic      [31:0]           cfg_rdata_out,
  output logic                       cfg_rvalid_out,
  // JTAG side status view
  output logic      [31:0]           jtag_status_out,
  // Frame word output toward the array
  output logic                       frame_wr_out,
  output logic      [31:0]           frame_addr_out,
  output logic      [5:0]            frame_word_idx_out,
  output logic      [31:0]           frame_data_out,
  output logic                       frame_done_out,
  output logic                       normal_load_end_out,
  // Checks from the packet and decryption logic
  input  wire logic                  device_identifier_check_in,
  input  wire logic                  decrypt_enabled_in,
  input  wire logic                  decrypt_active_in,
  input  wire logic                  crc_mismatch_in,
  input  wire logic                  crc_reset_in,
  // Global signals from startup and control
  input  wire logic                  release_done_in,
  input  wire logic                  init_complete_in,
  input  wire logic                  global_high_n_in,
  input  wire logic                  global_write_enable_in,
  input  wire logic                  global_three_state_n_in,
  input  wire logic                  startup_finished_in,
  input  wire logic [NUM_BANKS-1:0]  impedance_matched_in,
  input  wire logic [NUM_CLKMGR-1:0] clock_managers_locked_in,
  input  wire logic                  decryptor_secured_in,
  // Device pins
  input  wire logic [2:0]            mode_pins_in,
  input  wire logic                  done_pin_in,
  input  wire logic                  init_pin_in
);
  import cfas_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic [2:0] mode_sync;
  logic       done_sync;
  logic       init_sync;

  // Pins are asynchronous to the configuration clock
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_s1_r <= 5'h00;
      pin_s2_r <= 5'h00;
    end else begin
      pin_s1_r <= {init_pin_in, done_pin_in, mode_pins_in};
      pin_s2_r <= pin_s1_r;
    end
  end

  // Only the second stage is ever read
  assign mode_sync = pin_s2_r[2:0];
  assign done_sync = pin_s2_r[3];
  assign init_sync = pin_s2_r[4];

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  logic wr_far;
  logic wr_frame_data_input;
  logic rd_far;
  logic rd_stat;
  logic id_bad;
  logic dec_bad;
  logic word_take;

  // Writes to the status select fall through: nothing changes
  assign wr_far  = cfg_wr_in && (cfg_sel_in == SEL_FAR);
  assign wr_frame_data_input = cfg_wr_in && (cfg_sel_in == SEL_FRAME_DATA_INPUT);
  assign rd_far  = cfg_rd_in && (cfg_sel_in == SEL_FAR);
  assign rd_stat = cfg_rd_in && (cfg_sel_in == SEL_STAT);

  // Data writes are checked before they reach the array
  assign id_bad    = wr_frame_data_input && !device_identifier_check_in;
  assign dec_bad   = wr_frame_data_input && decrypt_enabled_in && !decrypt_active_in;
  // Faulty words are dropped so the frame count stays honest
  assign word_take = wr_frame_data_input && !id_bad && !dec_bad;

  // ---------------------------------------------------------------
  // Frame address register
  // ---------------------------------------------------------------
  logic [31:0]          far_r;
  logic [31:0]          far_nxt;
  logic [ADDR_BITS-1:0] far_inc;
  logic                 half_bottom;
  logic [2:0]           blk_type;
  logic [4:0]           row_addr;
  logic [7:0]           col_addr;
  logic [5:0]           minor_addr;
  logic [2:0]           inc_type;
  logic                 load_end_r;
  logic                 load_end_nxt;

  cfas_frame_if fr ();

  // Field views of the held address
  assign half_bottom = far_r[HALF_BIT];
  assign blk_type    = far_r[TYPE_HI:TYPE_LO];
  assign row_addr    = far_r[ROW_HI:ROW_LO];
  assign col_addr    = far_r[COL_HI:COL_LO];
  assign minor_addr  = far_r[MINOR_HI:MINOR_LO];

  // Minor carries into column, column into row, row into type
  assign far_inc  = far_r[ADDR_BITS-1:0] + {{(ADDR_BITS-1){1'b0}}, 1'b1};
  assign inc_type = far_inc[TYPE_HI:TYPE_LO];

  // Direct write wins over the end-of-frame step
  assign far_nxt = wr_far ? {9'h000, cfg_wdata_in[ADDR_BITS-1:0]} :
                   fr.frame_done ? {9'h000, far_inc} : far_r;

  // A normal load is over once the step leaves memory content frames
  assign load_end_nxt = wr_far ? 1'b0 :
                        (fr.frame_done && (blk_type == TYPE_MEMCT) &&
                         (inc_type != TYPE_MEMCT)) ? 1'b1 : load_end_r;

  // Address holder
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      far_r      <= FAR_RESET;
      load_end_r <= 1'b0;
    end else begin
      far_r      <= far_nxt;
      load_end_r <= load_end_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Word sequencer
  // ---------------------------------------------------------------
  // A new address restarts the word count of the frame
  assign fr.word_ok = word_take;
  assign fr.bottom  = half_bottom;
  assign fr.restart = wr_far;

  cfas_word_seq u_seq (
    .sys_clk_in (sys_clk_in),
    .nrst_in    (nrst_in),
    .fr         (fr)
  );

  // ---------------------------------------------------------------
  // Frame word steering
  // ---------------------------------------------------------------
  logic [31:0] word_rev;
  logic [31:0] word_out;
  logic        fwr_r;
  logic [31:0] faddr_r;
  logic [5:0]  fidx_r;
  logic [31:0] fdata_r;
  logic        fdone_r;

  // Bottom words are bit-mirrored; clock row title bits are not
  assign word_rev = {<<{cfg_wdata_in}};
  assign word_out = fr.keep_order ? cfg_wdata_in : word_rev;

  // Registered so the array sees clean, aligned strobes
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fwr_r   <= 1'b0;
      faddr_r <= FAR_RESET;
      fidx_r  <= 6'h00;
      fdata_r <= 32'h0000_0000;
      fdone_r <= 1'b0;
    end else begin
      fwr_r   <= word_take;
      faddr_r <= far_r;
      fidx_r  <= fr.place_idx;
      fdata_r <= word_out;
      fdone_r <= fr.frame_done;
    end
  end

  // ---------------------------------------------------------------
  // Sticky fault flags
  // ---------------------------------------------------------------
  logic dec_err_r;
  logic id_err_r;
  logic crc_err_r;
  logic dec_err_nxt;
  logic id_err_nxt;
  logic crc_err_nxt;

  // Faults stay until reset; a checksum reset clears the mismatch,
  // but a mismatch in the same cycle still wins
  assign dec_err_nxt = dec_bad || dec_err_r;
  assign id_err_nxt  = id_bad || id_err_r;
  assign crc_err_nxt = crc_mismatch_in || (crc_err_r && !crc_reset_in);

  // Fault flag registers
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dec_err_r <= 1'b0;
      id_err_r  <= 1'b0;
      crc_err_r <= 1'b0;
    end else begin
      dec_err_r <= dec_err_nxt;
      id_err_r  <= id_err_nxt;
      crc_err_r <= crc_err_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Status word assembly
  // ---------------------------------------------------------------
  logic        match_all;
  logic        lock_all;
  logic [31:0] stat_w;
  logic [31:0] stat_r;

  // Unused banks and managers are tied high by their owners
  assign match_all = &impedance_matched_in;
  assign lock_all  = &clock_managers_locked_in;

  // Upper bits stay zero; nothing here is writable
  always_comb begin
    stat_w                        = 32'h0000_0000;
    stat_w[ST_DECRYPT]            = dec_err_r;
    stat_w[ST_IDENT]              = id_err_r;
    stat_w[ST_DONEPIN]            = done_sync;
    stat_w[ST_RELEASE]            = release_done_in;
    stat_w[ST_INITPIN]            = init_sync;
    stat_w[ST_INITOK]             = init_complete_in;
    stat_w[ST_MODE_HI:ST_MODE_LO] = mode_sync;
    stat_w[ST_GHIGH]              = global_high_n_in;
    stat_w[ST_GWE]                = global_write_enable_in;
    stat_w[ST_GTS]                = global_three_state_n_in;
    stat_w[ST_EOS]                = startup_finished_in;
    stat_w[ST_MATCH]              = match_all;
    stat_w[ST_LOCK]               = lock_all;
    stat_w[ST_SECURE]             = decryptor_secured_in;
    stat_w[ST_CRC]                = crc_err_r;
  end

  // Status snapshot, one cycle behind its sources
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stat_r <= 32'h0000_0000;
    end else begin
      stat_r <= stat_w;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] rdata_r;
  logic        rvalid_r;

  // Unknown selects read back zero rather than stale data
  assign rd_mux = rd_far ? far_r :
                  rd_stat ? stat_w : 32'h0000_0000;

  // Read answer, one cycle after the strobe
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_r  <= 32'h0000_0000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= cfg_rd_in ? rd_mux : rdata_r;
      rvalid_r <= cfg_rd_in;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign cfg_rdata_out       = rdata_r;
  assign cfg_rvalid_out      = rvalid_r;
  assign jtag_status_out     = stat_r;
  assign frame_wr_out        = fwr_r;
  assign frame_addr_out      = faddr_r;
  assign frame_word_idx_out  = fidx_r;
  assign frame_data_out      = fdata_r;
  assign frame_done_out      = fdone_r;
  assign normal_load_end_out = load_end_r;
endmodule
`default_nettype wire

/* File: tb/cfas_monitor.sv */
// Port checker for the frame address and status block
`default_nettype none
module cfas_monitor
  import cfas_pkg::*;
(
  input wire logic                  sys_clk_in,
  input wire logic                  nrst_in,
  input wire logic                  cfg_wr_in,
  input wire logic                  cfg_rd_in,
  input wire logic [4:0]            cfg_sel_in,
  input wire logic                  cfg_rvalid_out,
  input wire logic [31:0]           jtag_status_out,
  input wire logic                  frame_wr_out,
  input wire logic                  frame_done_out,
  input wire logic                  device_identifier_check_in,
  input wire logic                  decrypt_enabled_in,
  input wire logic                  decrypt_active_in,
  input wire logic                  crc_mismatch_in,
  input wire logic                  global_write_enable_in,
  input wire logic                  startup_finished_in,
  input wire logic [NUM_BANKS-1:0]  impedance_matched_in,
  input wire logic [NUM_CLKMGR-1:0] clock_managers_locked_in,
  input wire logic [2:0]            mode_pins_in
);
  logic [2:0] up_cnt_r;
  logic [2:0] up_cnt_nxt;
  logic       up_ok;
  logic       frame_data_input_wr;
  // Lagged status compares wait until the sync pipe holds post-reset samples
  assign up_cnt_nxt = (up_cnt_r == 3'h7) ? up_cnt_r : up_cnt_r + 3'h1;
  assign up_ok      = (up_cnt_r >= 3'h5);
  assign frame_data_input_wr    = cfg_wr_in && (cfg_sel_in == SEL_FRAME_DATA_INPUT);
  // Cycles since reset release
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      up_cnt_r <= 3'h0;
    end else begin
      up_cnt_r <= up_cnt_nxt;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  a_read_answer: assert property (cfg_rd_in |=> cfg_rvalid_out)
    else $error("read not answered next cycle");
  a_answer_cause: assert property (cfg_rvalid_out |-> $past(cfg_rd_in))
    else $error("read valid without a read");
  a_upper_zero: assert property (jtag_status_out[31:17] == 15'h0)
    else $error("status upper bits not zero");
  a_lock_and: assert property (up_ok |-> jtag_status_out[ST_LOCK] == $past(&clock_managers_locked_in))
    else $error("lock bit is not the AND of locks");
  a_match_and: assert property (up_ok |-> jtag_status_out[ST_MATCH] == $past(&impedance_matched_in))
    else $error("match bit is not the AND of banks");
  a_gwe_eos_copy: assert property (up_ok |-> jtag_status_out[ST_GWE] == $past(global_write_enable_in)
    && jtag_status_out[ST_EOS] == $past(startup_finished_in))
    else $error("write enable or startup bit wrong");
  a_mode_lag: assert property (up_ok |-> jtag_status_out[10:8] == $past(mode_pins_in, 3))
    else $error("mode bits do not follow pins");
  a_ident_fault: assert property (frame_data_input_wr && !device_identifier_check_in |-> ##3 jtag_status_out[ST_IDENT])
    else $error("identifier fault not flagged");
  a_decrypt_fault: assert property (frame_data_input_wr && decrypt_enabled_in && !decrypt_active_in
    |-> ##3 jtag_status_out[ST_DECRYPT])
    else $error("decrypt order fault not flagged");
  a_crc_sticky: assert property (crc_mismatch_in |-> ##2 jtag_status_out[ST_CRC])
    else $error("checksum mismatch not flagged");
  a_word_accept: assert property (frame_wr_out |-> $past(frame_data_input_wr && device_identifier_check_in))
    else $error("frame word without a valid data write");
  a_done_word: assert property (frame_done_out |-> frame_wr_out)
    else $error("frame end without a word");
endmodule
bind cfas_top cfas_monitor i_cfas_monitor (.*);
`default_nettype wire

/* File: tb/cfas_cfg_master.sv */
// Behavioural configuration master on the register port
`default_nettype none
module cfas_cfg_master
  import cfas_pkg::*;
(
  input  wire logic        sys_clk_in,
  output logic             cfg_wr_out,
  output logic             cfg_rd_out,
  output logic [4:0]       cfg_sel_out,
  output logic [31:0]      cfg_wdata_out,
  input  wire logic [31:0] cfg_rdata_in,
  input  wire logic        cfg_rvalid_in
);
  int unsigned gap = 0;
  // Quiet bus at time zero
  initial begin
    cfg_wr_out = 1'b0;
    cfg_rd_out = 1'b0;
    cfg_sel_out = 5'h00;
    cfg_wdata_out = 32'h0000_0000;
  end
  // Released lines show inverted values so stale data never passes
  task automatic idle();
    cfg_wr_out = 1'b0;
    cfg_rd_out = 1'b0;
    cfg_sel_out = ~cfg_sel_out;
    cfg_wdata_out = ~cfg_wdata_out;
    repeat (gap) @(negedge sys_clk_in);
  endtask
  // Back-to-back words, one strobe per cycle
  task automatic burst(input logic [4:0] sel, input logic [31:0] base, input int unsigned n);
    for (int unsigned i = 0; i < n; i++) begin
      @(negedge sys_clk_in);
      cfg_wr_out = 1'b1;
      cfg_sel_out = sel;
      cfg_wdata_out = base + i;
    end
    @(negedge sys_clk_in);
    idle();
  endtask
  // One-cycle read strobe; answer stands the cycle after the read edge
  task automatic read(input logic [4:0] sel, output logic [31:0] data);
    @(negedge sys_clk_in);
    cfg_rd_out = 1'b1;
    cfg_sel_out = sel;
    @(negedge sys_clk_in);
    data = (cfg_rvalid_in === 1'b1) ? cfg_rdata_in : 32'hxxxx_xxxx;
    idle();
  endtask
endmodule
`default_nettype wire

/* File: tb/cfas_top_tb.sv */
// Self-checking bench for the frame address and status block
`default_nettype none
module cfas_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cfas_pkg::*;
  logic sys_clk_in, nrst_in, cfg_wr, cfg_rd, rvalid, f_wr, f_done, load_end;
  logic id_ok, dec_en, dec_act, crc_bad, crc_clr, rel_done, init_ok, ghigh_n;
  logic global_write_enable, gts_n, startup_finished, secured, done_pin, init_pin, id_f, dec_f, crc_f;
  logic [4:0]  cfg_sel;
  logic [31:0] cfg_wdata, rdata, jtag, f_addr, f_data, v;
  logic [5:0]  f_idx;
  logic [7:0]  match;
  logic [3:0]  lock;
  logic [2:0]  mode;
  logic [31:0] got_dat [0:63];
  logic [31:0] got_adr [0:63];
  logic [5:0]  got_idx [0:63];
  int          n_wr, n_done, err_total, samples_checked;
  logic [15:0] pats [4] = '{16'h0000, 16'h3fff, 16'h2a55, 16'h15aa};
  cfas_top i_cfas_top (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .cfg_wr_in(cfg_wr),
    .cfg_rd_in(cfg_rd), .cfg_sel_in(cfg_sel), .cfg_wdata_in(cfg_wdata), .cfg_rdata_out(rdata),
    .cfg_rvalid_out(rvalid), .jtag_status_out(jtag), .frame_wr_out(f_wr), .frame_addr_out(f_addr),
    .frame_word_idx_out(f_idx), .frame_data_out(f_data), .frame_done_out(f_done),
    .normal_load_end_out(load_end), .device_identifier_check_in(id_ok), .decrypt_enabled_in(dec_en),
    .decrypt_active_in(dec_act), .crc_mismatch_in(crc_bad), .crc_reset_in(crc_clr),
    .release_done_in(rel_done), .init_complete_in(init_ok), .global_high_n_in(ghigh_n),
    .global_write_enable_in(global_write_enable), .global_three_state_n_in(gts_n), .startup_finished_in(startup_finished),
    .impedance_matched_in(match), .clock_managers_locked_in(lock), .decryptor_secured_in(secured),
    .mode_pins_in(mode), .done_pin_in(done_pin), .init_pin_in(init_pin));
  cfas_cfg_master i_cfas_cfg_master (.sys_clk_in(sys_clk_in), .cfg_wr_out(cfg_wr), .cfg_rd_out(cfg_rd),
    .cfg_sel_out(cfg_sel), .cfg_wdata_out(cfg_wdata), .cfg_rdata_in(rdata), .cfg_rvalid_in(rvalid));
  // Clock
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  // Record accepted frame words as sampled at each rising edge
  always @(posedge sys_clk_in) begin
    if (f_wr === 1'b1 && n_wr < 64) begin
      got_dat[n_wr] = f_data;
      got_adr[n_wr] = f_addr;
      got_idx[n_wr] = f_idx;
      n_wr++;
    end
    if (f_done === 1'b1) n_done++;
  end
  function automatic logic [31:0] exp_stat();
    return {15'h0, dec_f, id_f, done_pin, rel_done, init_pin, init_ok, mode, ghigh_n, global_write_enable, gts_n,
            startup_finished, &match, &lock, secured, crc_f};
  endfunction
  function automatic logic [31:0] rev32(input logic [31:0] d);
    logic [31:0] r;
    r = {<<{d}};
    return r;
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd_chk(input string nm, input logic [4:0] sel, input logic [31:0] exp);
    i_cfas_cfg_master.read(sel, v);
    chk(nm, exp, v);
  endtask
  // Status read on both views once the pin syncs have settled
  task automatic stat_chk();
    repeat (5) @(negedge sys_clk_in);
    rd_chk("status", SEL_STAT, exp_stat());
    chk("jtag status", exp_stat(), jtag);
  endtask
  // One whole frame from a written start address
  task automatic do_frame(input logic [31:0] frame_address, input logic [31:0] nxt, input logic [31:0] base);
    i_cfas_cfg_master.burst(SEL_FAR, frame_address, 1);
    n_wr = 0;
    n_done = 0;
    i_cfas_cfg_master.burst(SEL_FRAME_DATA_INPUT, base, FRAME_WORDS);
    repeat (2) @(negedge sys_clk_in);
    chk("word count", 32'(FRAME_WORDS), 32'(n_wr));
    chk("frame end", 32'h0000_0001, 32'(n_done));
    chk("word address", frame_address, got_adr[0]);
    rd_chk("next address", SEL_FAR, nxt);
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard, well past the expected run length
  initial begin
    #16000;
    err_total++;
    test_done();
  end
  // Main sequence
  initial begin
    {nrst_in, dec_en, dec_act, crc_bad, crc_clr, id_f, dec_f, crc_f} = 8'h00;
    {rel_done, init_ok, ghigh_n, global_write_enable, gts_n, startup_finished, secured, done_pin, init_pin} = 9'h000;
    {id_ok, match, lock, mode} = 16'h0000;
    n_wr = 0;
    n_done = 0;
    err_total = 0;
    samples_checked = 0;
    repeat (12) @(negedge sys_clk_in);
    nrst_in = 1'b1;
    foreach (pats[i]) begin
      {rel_done, init_ok, ghigh_n, global_write_enable, gts_n, startup_finished, secured, done_pin, init_pin} = pats[i][8:0];
      mode = pats[i][11:9];
      match = pats[i][12] ? 8'hff : 8'hef;
      lock = pats[i][13] ? 4'hf : 4'hb;
      stat_chk();
    end
    i_cfas_cfg_master.gap = 3;
    i_cfas_cfg_master.burst(SEL_STAT, 32'hffff_ffff, 1);
    stat_chk();
    rd_chk("unmapped", 5'h1f, 32'h0000_0000);
    i_cfas_cfg_master.burst(SEL_FAR, 32'hffff_ffff, 1);
    rd_chk("address mask", SEL_FAR, 32'h007f_ffff);
    i_cfas_cfg_master.gap = 0;
    id_ok = 1'b1;
    do_frame(32'h0000_0000, 32'h0000_0001, 32'h1234_5678);
    chk("top first data", 32'h1234_5678, got_dat[0]);
    chk("top last index", 32'h0000_0028, 32'(got_idx[40]));
    do_frame(32'h0000_003f, 32'h0000_0040, 32'h0000_0100);
    do_frame(32'h0000_3fff, 32'h0000_4000, 32'h0000_0200);
    do_frame(32'h0017_ffff, 32'h0018_0000, 32'h0000_0300);
    chk("load end", 32'h0000_0001, 32'(load_end));
    i_cfas_cfg_master.burst(SEL_FAR, 32'h0000_0000, 1);
    @(negedge sys_clk_in);
    chk("load end clear", 32'h0000_0000, 32'(load_end));
    do_frame(32'h0040_0000, 32'h0040_0001, 32'h8000_0003);
    chk("bottom index", 32'h0000_0028, 32'(got_idx[0]));
    chk("bottom data", rev32(32'h8000_0003), got_dat[0]);
    chk("clock row data", 32'h8000_0017, got_dat[20]);
    n_wr = 0;
    id_ok = 1'b0;
    i_cfas_cfg_master.burst(SEL_FRAME_DATA_INPUT, 32'h0000_0001, 1);
    id_f = 1'b1;
    stat_chk();
    id_ok = 1'b1;
    dec_en = 1'b1;
    i_cfas_cfg_master.burst(SEL_FRAME_DATA_INPUT, 32'h0000_0002, 1);
    dec_f = 1'b1;
    stat_chk();
    chk("dropped words", 32'h0000_0000, 32'(n_wr));
    dec_act = 1'b1;
    i_cfas_cfg_master.burst(SEL_FRAME_DATA_INPUT, 32'h0000_0003, 1);
    repeat (2) @(negedge sys_clk_in);
    chk("accepted word", 32'h0000_0001, 32'(n_wr));
    crc_bad = 1'b1;
    @(negedge sys_clk_in);
    crc_bad = 1'b0;
    crc_f = 1'b1;
    stat_chk();
    crc_clr = 1'b1;
    @(negedge sys_clk_in);
    crc_clr = 1'b0;
    crc_f = 1'b0;
    stat_chk();
    nrst_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    nrst_in = 1'b1;
    {id_f, dec_f} = 2'h0;
    stat_chk();
    test_done();
  end
endmodule
`default_nettype wire
